/* hdl/status_frame_pkg.sv */
// constants for the status frame builder
package status_frame_pkg;
  localparam logic [7:0]  START_DELIM      = 8'h7E;
  localparam logic [7:0]  CKSUM_BASE       = 8'hFF;
  localparam logic [7:0]  TYPE_MODEM       = 8'h8A;
  localparam logic [7:0]  TYPE_TX_STATUS   = 8'h89;
  localparam logic [7:0]  TYPE_TX_EXT      = 8'h8B;
  localparam logic [7:0]  REQ_TX_64        = 8'h00;
  localparam logic [7:0]  REQ_TX_16        = 8'h01;
  localparam logic [7:0]  REQ_RELAY        = 8'h2D;
  localparam logic [7:0]  REQ_TRANSMIT     = 8'h10;
  localparam logic [7:0]  REQ_EXPLICIT     = 8'h11;
  localparam logic [15:0] RESERVED_FILL    = 16'hFFFE;
  localparam logic [7:0]  MODEM_POWER_UP   = 8'h00;
  localparam logic [7:0]  MODEM_WATCHDOG   = 8'h01;
  localparam logic [7:0]  MODEM_NET_WAKE   = 8'h0B;
  localparam logic [7:0]  MODEM_NET_SLEEP  = 8'h0C;
  localparam logic [7:0]  MODEM_VOLTAGE    = 8'h0D;
  localparam logic [7:0]  MODEM_SEC_UP     = 8'h3B;
  localparam logic [7:0]  MODEM_SEC_END    = 8'h3C;
  localparam logic [7:0]  MODEM_SEC_AUTH   = 8'h3D;
  localparam logic [7:0]  MODEM_WL_CONNECT = 8'h32;
  localparam logic [7:0]  MODEM_WL_DISC    = 8'h33;
  localparam logic [7:0]  MODEM_NO_SEC     = 8'h34;
  localparam logic [7:0]  DLV_SUCCESS      = 8'h00;
  localparam logic [7:0]  DLV_MAC_ACK      = 8'h01;
  localparam logic [7:0]  DLV_CCA          = 8'h02;
  localparam logic [7:0]  DLV_INDIRECT     = 8'h03;
  localparam logic [7:0]  DLV_NET_ACK      = 8'h21;
  localparam logic [7:0]  DLV_NO_ROUTE     = 8'h25;
  localparam logic [7:0]  DLV_INTERNAL     = 8'h31;
  localparam logic [7:0]  DLV_RESOURCE     = 8'h32;
  localparam logic [7:0]  DLV_TOO_LARGE    = 8'h74;
  localparam logic [7:0]  DLV_IND_UNREQ    = 8'h75;
  localparam logic [7:0]  DISC_NONE        = 8'h00;
  localparam logic [7:0]  DISC_ROUTE       = 8'h02;
  localparam int          MAX_PAYLOAD      = 7;
  localparam logic [15:0] LEN_MODEM        = 16'h0002;
  localparam logic [15:0] LEN_TX_STATUS    = 16'h0003;
  localparam logic [15:0] LEN_TX_EXT       = 16'h0007;
  localparam logic [3:0]  HEADER_BYTES     = 4'h3;
  // event selector codes on the modem event input
  localparam logic [3:0]  EV_WATCHDOG      = 4'h1;
  localparam logic [3:0]  EV_NET_WAKE      = 4'h2;
  localparam logic [3:0]  EV_NET_SLEEP     = 4'h3;
  localparam logic [3:0]  EV_VOLTAGE       = 4'h4;
  localparam logic [3:0]  EV_SEC_UP        = 4'h5;
  localparam logic [3:0]  EV_SEC_END       = 4'h6;
  localparam logic [3:0]  EV_SEC_AUTH      = 4'h7;
  localparam logic [3:0]  EV_WL_CONNECT    = 4'h8;
  localparam logic [3:0]  EV_WL_DISC       = 4'h9;
  localparam logic [3:0]  EV_NO_SEC        = 4'hA;
  // outcome codes on the transmit outcome input
  localparam logic [3:0]  OUT_SUCCESS      = 4'h0;
  localparam logic [3:0]  OUT_MAC_ACK      = 4'h1;
  localparam logic [3:0]  OUT_CCA          = 4'h2;
  localparam logic [3:0]  OUT_INDIRECT     = 4'h3;
  localparam logic [3:0]  OUT_NET_ACK      = 4'h4;
  localparam logic [3:0]  OUT_NO_ROUTE     = 4'h5;
  localparam logic [3:0]  OUT_INTERNAL     = 4'h6;
  localparam logic [3:0]  OUT_RESOURCE     = 4'h7;
  localparam logic [3:0]  OUT_TOO_LARGE    = 4'h8;
  localparam logic [3:0]  OUT_IND_UNREQ    = 4'h9;
endpackage : status_frame_pkg

/* hdl/frame_checksum.sv */
// running checksum over the bytes between length and checksum
module frame_checksum
  import status_frame_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // byte stream
  input  wire logic       clear_i,
  input  wire logic       add_i,
  input  wire logic [7:0] byte_i,
  // result
  output logic      [7:0] cksum_o
);
  import status_frame_pkg::*;

  typedef struct packed {
    logic [7:0] sum;
  } cksum_state_t;

  cksum_state_t state_reg;
  cksum_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (clear_i) begin
      state_next.sum = 8'h00;
    end else if (add_i) begin
      state_next.sum = state_reg.sum + byte_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cksum_o = CKSUM_BASE - state_reg.sum;
endmodule : frame_checksum

/* hdl/api_status_frame_builder.sv */
// status frame builder: modem status, transmit status, extended transmit status
module api_status_frame_builder
  import status_frame_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // modem events
  input  wire logic       modem_valid_i,
  input  wire logic [3:0] modem_event_i,
  output logic            modem_ready_o,
  // transmit outcomes
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_req_type_i,
  input  wire logic [7:0] tx_frame_id_i,
  input  wire logic       tx_broadcast_i,
  input  wire logic [3:0] tx_outcome_i,
  input  wire logic [7:0] tx_retries_i,
  input  wire logic       tx_route_disc_i,
  output logic            tx_ready_o,
  // byte stream toward the serial port
  output logic            out_valid_o,
  output logic [7:0]      out_data_o,
  output logic            out_last_o,
  input  wire logic       out_ready_i
);
  import status_frame_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // decoding

  function automatic logic [7:0] modem_code(input logic [3:0] ev);
    case (ev)
      EV_WATCHDOG:   modem_code = MODEM_WATCHDOG;
      EV_NET_WAKE:   modem_code = MODEM_NET_WAKE;
      EV_NET_SLEEP:  modem_code = MODEM_NET_SLEEP;
      EV_VOLTAGE:    modem_code = MODEM_VOLTAGE;
      EV_SEC_UP:     modem_code = MODEM_SEC_UP;
      EV_SEC_END:    modem_code = MODEM_SEC_END;
      EV_SEC_AUTH:   modem_code = MODEM_SEC_AUTH;
      EV_WL_CONNECT: modem_code = MODEM_WL_CONNECT;
      EV_WL_DISC:    modem_code = MODEM_WL_DISC;
      EV_NO_SEC:     modem_code = MODEM_NO_SEC;
      default:       modem_code = MODEM_POWER_UP;
    endcase
  endfunction : modem_code

  function automatic logic [7:0] delivery_code(input logic [3:0] oc, input logic bcast);
    if (bcast) begin
      delivery_code = DLV_SUCCESS;
    end else begin
      case (oc)
        OUT_MAC_ACK:   delivery_code = DLV_MAC_ACK;
        OUT_CCA:       delivery_code = DLV_CCA;
        OUT_INDIRECT:  delivery_code = DLV_INDIRECT;
        OUT_NET_ACK:   delivery_code = DLV_NET_ACK;
        OUT_NO_ROUTE:  delivery_code = DLV_NO_ROUTE;
        OUT_INTERNAL:  delivery_code = DLV_INTERNAL;
        OUT_RESOURCE:  delivery_code = DLV_RESOURCE;
        OUT_TOO_LARGE: delivery_code = DLV_TOO_LARGE;
        OUT_IND_UNREQ: delivery_code = DLV_IND_UNREQ;
        default:       delivery_code = DLV_SUCCESS;
      endcase
    end
  endfunction : delivery_code

  function automatic logic is_ext_req(input logic [7:0] t);
    is_ext_req = (t == REQ_TRANSMIT) || (t == REQ_EXPLICIT);
  endfunction : is_ext_req

  function automatic logic is_plain_req(input logic [7:0] t);
    is_plain_req = (t == REQ_TX_64) || (t == REQ_TX_16) || (t == REQ_RELAY);
  endfunction : is_plain_req

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_IDLE,
    ST_DELIM,
    ST_LEN_HI,
    ST_LEN_LO,
    ST_BODY,
    ST_CKSUM
  } phase_t;

  typedef struct packed {
    phase_t        phase;
    logic [15:0]   length;
    logic [7:0][7:0] body;
    logic [3:0]    index;
    logic          valid;
    logic [7:0]    data;
    logic          last;
    logic          modem_ready;
    logic          tx_ready;
  } builder_state_t;

  builder_state_t state_reg;
  builder_state_t state_next;

  logic       ck_clear;
  logic       ck_add;
  logic [7:0] ck_value;
  logic       accept;
  logic       take_tx;
  logic       tx_wanted;

  //////////////////////////////////////////////////////////////////////////////
  // next state

  // a byte leaves when the output register is empty or being taken
  assign accept = !state_reg.valid || out_ready_i;
  assign tx_wanted = tx_valid_i && (tx_frame_id_i != 8'h00)
                     && (is_ext_req(tx_req_type_i) || is_plain_req(tx_req_type_i));
  // transmit outcomes win over modem events; zero-identifier requests are dropped
  assign take_tx = tx_valid_i;

  always_comb begin
    state_next = state_reg;
    state_next.modem_ready = 1'b0;
    state_next.tx_ready = 1'b0;
    ck_clear = 1'b0;
    ck_add = 1'b0;
    if (accept) begin
      state_next.valid = 1'b0;
      state_next.last = 1'b0;
    end
    case (state_reg.phase)
      ST_BOOT: begin
        state_next.body[0] = TYPE_MODEM;
        state_next.body[1] = MODEM_POWER_UP;
        state_next.length = LEN_MODEM;
        state_next.phase = ST_DELIM;
      end
      ST_IDLE: begin
        ck_clear = 1'b1;
        if (take_tx && !state_reg.tx_ready) begin
          state_next.tx_ready = 1'b1;
          if (tx_wanted) begin
            state_next.body[1] = tx_frame_id_i;
            state_next.phase = ST_DELIM;
            if (is_ext_req(tx_req_type_i)) begin
              state_next.length = LEN_TX_EXT;
              state_next.body[0] = TYPE_TX_EXT;
              state_next.body[2] = RESERVED_FILL[15:8];
              state_next.body[3] = RESERVED_FILL[7:0];
              state_next.body[4] = tx_retries_i;
              state_next.body[5] = delivery_code(tx_outcome_i, tx_broadcast_i);
              state_next.body[6] = tx_route_disc_i ? DISC_ROUTE : DISC_NONE;
            end else begin
              state_next.length = LEN_TX_STATUS;
              state_next.body[0] = TYPE_TX_STATUS;
              state_next.body[2] = delivery_code(tx_outcome_i, tx_broadcast_i);
            end
          end
        end else if (modem_valid_i && !take_tx && !state_reg.modem_ready) begin
          state_next.modem_ready = 1'b1;
          state_next.length = LEN_MODEM;
          state_next.body[0] = TYPE_MODEM;
          state_next.body[1] = modem_code(modem_event_i);
          state_next.phase = ST_DELIM;
        end
      end
      ST_DELIM: begin
        if (accept) begin
          state_next.valid = 1'b1;
          state_next.data = START_DELIM;
          state_next.phase = ST_LEN_HI;
        end
      end
      ST_LEN_HI: begin
        if (accept) begin
          state_next.valid = 1'b1;
          state_next.data = state_reg.length[15:8];
          state_next.phase = ST_LEN_LO;
        end
      end
      ST_LEN_LO: begin
        if (accept) begin
          state_next.valid = 1'b1;
          state_next.data = state_reg.length[7:0];
          state_next.index = 4'h0;
          state_next.phase = ST_BODY;
        end
      end
      ST_BODY: begin
        if (accept) begin
          state_next.valid = 1'b1;
          state_next.data = state_reg.body[state_reg.index[2:0]];
          ck_add = 1'b1;
          state_next.index = state_reg.index + 4'h1;
          if ({12'h000, state_reg.index} == state_reg.length - 16'h0001) begin
            state_next.phase = ST_CKSUM;
          end
        end
      end
      ST_CKSUM: begin
        if (accept) begin
          state_next.valid = 1'b1;
          state_next.data = ck_value;
          state_next.last = 1'b1;
          state_next.phase = ST_IDLE;
        end
      end
      default: begin
        state_next.phase = ST_IDLE;
      end
    endcase
  end

  frame_checksum u_checksum (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .clear_i (ck_clear),
    .add_i   (ck_add),
    .byte_i  (state_reg.body[state_reg.index[2:0]]),
    .cksum_o (ck_value)
  );

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg <= '0;
      state_reg.phase <= ST_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  assign modem_ready_o = state_reg.modem_ready;
  assign tx_ready_o    = state_reg.tx_ready;
  assign out_valid_o   = state_reg.valid;
  assign out_data_o    = state_reg.data;
  assign out_last_o    = state_reg.last;
endmodule : api_status_frame_builder

/* verif/api_status_frame_builder_sva.sv */
// assertions on the status frame builder ports
module api_status_frame_builder_sva (
  // clock and reset
  input wire logic       clock_i,
  input wire logic       srst_i,
  // requests
  input wire logic       tx_ready_o,
  input wire logic [7:0] tx_req_type_i,
  input wire logic [7:0] tx_frame_id_i,
  input wire logic       modem_ready_o,
  // byte stream
  input wire logic       out_valid_o,
  input wire logic [7:0] out_data_o,
  input wire logic       out_last_o,
  input wire logic       out_ready_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idx_reg;
  logic [7:0] sum_reg;
  logic [7:0] len_reg;
  logic       beat;
  assign beat = out_valid_o && out_ready_i;
  // offset counter and running sum of the accepted bytes from offset 3 up to the checksum
  always_ff @(posedge clock_i) begin
    if (srst_i || (beat && out_last_o)) begin
      idx_reg <= 4'h0;
      sum_reg <= 8'h00;
    end else if (beat) begin
      idx_reg <= idx_reg + 4'h1;
      sum_reg <= (idx_reg >= 4'h3) ? sum_reg + out_data_o : sum_reg;
      len_reg <= (idx_reg == 4'h2) ? out_data_o : len_reg;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence frame_start_s;
    out_valid_o && idx_reg == 4'h0 && out_data_o == 8'h7e;
  endsequence
  sequence quiet_s;
    !out_valid_o [*6];
  endsequence
  start_delim_a: assert property (
    out_valid_o && idx_reg == 4'h0 |-> out_data_o == 8'h7e) else $error("no start byte");
  len_high_a: assert property (
    out_valid_o && idx_reg == 4'h1 |-> out_data_o == 8'h00) else $error("length high byte");
  len_count_a: assert property (
    beat && out_last_o |-> {4'h0, idx_reg} == len_reg + 8'h03) else $error("length count");
  checksum_value_a: assert property (
    out_valid_o && out_last_o |-> out_data_o == 8'hff - sum_reg) else $error("bad checksum");
  byte_hold_a: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o) && $stable(out_last_o))
    else $error("byte not held");
  no_gap_a: assert property (
    beat && !out_last_o |=> out_valid_o) else $error("gap inside frame");
  tx_frame_a: assert property (
    tx_ready_o && tx_frame_id_i != 8'h00
      && tx_req_type_i inside {8'h00, 8'h01, 8'h2d, 8'h10, 8'h11}
    |-> ##[1:4] frame_start_s) else $error("no status frame");
  zero_id_a: assert property (
    tx_ready_o && tx_frame_id_i == 8'h00 |=> quiet_s) else $error("frame for id zero");
  modem_frame_a: assert property (
    modem_ready_o |-> ##[1:4] frame_start_s) else $error("no modem frame");
endmodule : api_status_frame_builder_sva

bind api_status_frame_builder api_status_frame_builder_sva u_sva (
  .clock_i, .srst_i, .tx_ready_o, .tx_req_type_i, .tx_frame_id_i, .modem_ready_o,
  .out_valid_o, .out_data_o, .out_last_o, .out_ready_i
);

/* verif/host_frame_sink.sv */
// host side sink: collects frame bytes, can stall
module host_frame_sink (
  // clock
  input  wire logic       clock_i,
  // control from the bench
  input  wire logic       stall_i,
  // byte stream from the builder
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  output logic            ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  int         frames = 0;
  logic [1:0] phase = 2'h0;
  initial ready_o = 1'b1;
  // stalling holds ready low two cycles of three, a slow host
  always @(negedge clock_i) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    ready_o <= !stall_i || phase == 2'h0;
  end
  // bytes kept in wire order, so a swapped length shows up
  always @(posedge clock_i) begin
    if (valid_i && ready_o) begin
      rx_q.push_back(data_i);
      frames = frames + (last_i ? 1 : 0);
    end
  end
endmodule : host_frame_sink

/* verif/test_api_status_frame_builder.sv */
// self-checking bench for the status frame builder
module test_api_status_frame_builder;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       modem_valid_i = 1'b0;
  logic [3:0] modem_event_i = 4'h0;
  logic       modem_ready_o;
  logic       tx_valid_i = 1'b0;
  logic [7:0] tx_req_type_i = 8'h00;
  logic [7:0] tx_frame_id_i = 8'h00;
  logic       tx_broadcast_i = 1'b0;
  logic [3:0] tx_outcome_i = 4'h0;
  logic [7:0] tx_retries_i = 8'h00;
  logic       tx_route_disc_i = 1'b0;
  logic       tx_ready_o;
  logic       out_valid_o;
  logic [7:0] out_data_o;
  logic       out_last_o;
  logic       out_ready_i;
  logic       stall = 1'b0;
  int         fail_count = 0;
  int         checks = 0;
  int         cycles = 0;
  logic [7:0] dlv_tab [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h21, 8'h25, 8'h31, 8'h32,
                               8'h74, 8'h75};
  logic [7:0] ev_tab [10] = '{8'h01, 8'h0b, 8'h0c, 8'h0d, 8'h3b, 8'h3c, 8'h3d, 8'h32,
                              8'h33, 8'h34};
  api_status_frame_builder u_dut (.clock_i, .srst_i, .modem_valid_i, .modem_event_i,
    .modem_ready_o, .tx_valid_i, .tx_req_type_i, .tx_frame_id_i, .tx_broadcast_i,
    .tx_outcome_i, .tx_retries_i, .tx_route_disc_i, .tx_ready_o, .out_valid_o,
    .out_data_o, .out_last_o, .out_ready_i);
  host_frame_sink u_host (.clock_i, .stall_i(stall), .valid_i(out_valid_o),
    .data_i(out_data_o), .last_i(out_last_o), .ready_o(out_ready_i));
  initial forever #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_byte
  task automatic check_count(input string name, input int exp, input int got);
    checks++;
    if (got != exp) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_count
  // waits for the next whole frame and compares it byte by byte
  task automatic expect_frame(input logic [7:0] ft, input logic [7:0] pl[$]);
    logic [7:0] exp_q[$];
    logic [7:0] ck;
    int         n;
    n = u_host.frames + 1;
    ck = 8'hff - ft;
    exp_q = '{8'h7e, 8'h00, 8'(pl.size() + 1), ft};
    foreach (pl[i]) begin
      exp_q.push_back(pl[i]);
      ck = ck - pl[i];
    end
    exp_q.push_back(ck);
    repeat (300) if (u_host.frames < n) @(negedge clock_i);
    check_count("frames", n, u_host.frames);
    check_count("bytes", exp_q.size(), u_host.rx_q.size());
    foreach (exp_q[i]) check_byte("frame byte", exp_q[i], u_host.rx_q[i]);
    u_host.rx_q = {};
  endtask : expect_frame
  task automatic send_tx(input logic [7:0] ty, input logic [7:0] id, input logic bc,
                         input logic [3:0] oc, input logic [7:0] rt, input logic rd);
    @(negedge clock_i);
    {tx_req_type_i, tx_frame_id_i, tx_broadcast_i} = {ty, id, bc};
    {tx_outcome_i, tx_retries_i, tx_route_disc_i} = {oc, rt, rd};
    tx_valid_i = 1'b1;
    for (int k = 0; k < 400 && tx_ready_o !== 1'b1; k++) @(negedge clock_i);
    check_byte("tx ready", 8'h01, {7'h00, tx_ready_o});
    tx_valid_i = 1'b0;
  endtask : send_tx
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_modem;
    for (int i = 0; i < 10; i++) begin
      @(negedge clock_i);
      stall = i[0];
      modem_event_i = 4'(i + 1);
      modem_valid_i = 1'b1;
      for (int k = 0; k < 400 && modem_ready_o !== 1'b1; k++) @(negedge clock_i);
      check_byte("modem ready", 8'h01, {7'h00, modem_ready_o});
      modem_valid_i = 1'b0;
      expect_frame(8'h8a, '{ev_tab[i]});
    end
  endtask : test_modem
  task automatic test_status;
    logic [7:0] ty [3] = '{8'h00, 8'h01, 8'h2d};
    for (int i = 0; i < 9; i++) begin
      stall = i[1];
      send_tx(ty[i % 3], 8'(8'h52 + i), 1'b0, 4'(i), 8'h00, 1'b0);
      expect_frame(8'h89, '{8'(8'h52 + i), dlv_tab[i]});
    end
  endtask : test_status
  task automatic test_ext;
    for (int i = 0; i < 20; i++) begin
      stall = i[2];
      send_tx(i[0] ? 8'h11 : 8'h10, 8'(i + 1), 1'b0, 4'(i % 10), 8'(i * 13), i[1]);
      expect_frame(8'h8b, '{8'(i + 1), 8'hff, 8'hfe, 8'(i * 13), dlv_tab[i % 10],
                            i[1] ? 8'h02 : 8'h00});
    end
  endtask : test_ext
  // a failed broadcast still reports success in both frame kinds
  task automatic test_bcast;
    send_tx(8'h10, 8'h7f, 1'b1, 4'h5, 8'h02, 1'b1);
    expect_frame(8'h8b, '{8'h7f, 8'hff, 8'hfe, 8'h02, 8'h00, 8'h02});
    send_tx(8'h01, 8'hff, 1'b1, 4'h1, 8'h00, 1'b0);
    expect_frame(8'h89, '{8'hff, 8'h00});
  endtask : test_bcast
  // id zero is taken but silent; the next request must still work
  task automatic test_zero_id;
    int n;
    n = u_host.frames;
    send_tx(8'h10, 8'h00, 1'b0, 4'h1, 8'h01, 1'b0);
    send_tx(8'h00, 8'h00, 1'b0, 4'h0, 8'h00, 1'b0);
    // an unknown request type is acknowledged and dropped as well
    send_tx(8'h08, 8'h05, 1'b0, 4'h0, 8'h00, 1'b0);
    repeat (20) @(negedge clock_i);
    check_count("silent frames", n, u_host.frames);
    send_tx(8'h2d, 8'h01, 1'b0, 4'h9, 8'h00, 1'b0);
    expect_frame(8'h89, '{8'h01, 8'h75});
  endtask : test_zero_id
  // both requests at one edge: the outcome goes first, the event waits for idle
  task automatic test_priority;
    stall = 1'b0;
    @(negedge clock_i);
    {tx_req_type_i, tx_frame_id_i, tx_broadcast_i} = {8'h11, 8'h33, 1'b0};
    {tx_outcome_i, tx_retries_i, tx_route_disc_i} = {4'h2, 8'h01, 1'b0};
    tx_valid_i = 1'b1;
    modem_event_i = 4'hf;
    modem_valid_i = 1'b1;
    @(negedge clock_i);
    check_byte("tx first", 8'h02, {6'h00, tx_ready_o, modem_ready_o});
    tx_valid_i = 1'b0;
    expect_frame(8'h8b, '{8'h33, 8'hff, 8'hfe, 8'h01, 8'h02, 8'h00});
    for (int k = 0; k < 400 && modem_ready_o !== 1'b1; k++) @(negedge clock_i);
    check_byte("modem ready", 8'h01, {7'h00, modem_ready_o});
    modem_valid_i = 1'b0;
    expect_frame(8'h8a, '{8'h00});
  endtask : test_priority
  // reset in mid-frame cuts the frame and sends the power-up frame again
  task automatic test_reset;
    @(negedge clock_i);
    modem_event_i = 4'h3;
    modem_valid_i = 1'b1;
    for (int k = 0; k < 400 && modem_ready_o !== 1'b1; k++) @(negedge clock_i);
    modem_valid_i = 1'b0;
    repeat (3) @(negedge clock_i);
    srst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    check_byte("valid in reset", 8'h00, {7'h00, out_valid_o});
    u_host.rx_q = {};
    srst_i = 1'b0;
    expect_frame(8'h8a, '{8'h00});
  endtask : test_reset
  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(negedge clock_i);
    srst_i = 1'b0;
    expect_frame(8'h8a, '{8'h00});
    test_modem();
    test_status();
    test_ext();
    test_bcast();
    test_zero_id();
    test_priority();
    test_reset();
    finish_test();
  end
endmodule : test_api_status_frame_builder
